//--- src/cpu_status_and_data_memory_map.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Carry set on add carry or subtract borrow, cleared by other arithmetic.
// - Half carry set on nibble carry or borrow, cleared by other arithmetic.
// - Two user flags at status bits 5 and 1, software only.
// - Bank select bits 4:3 choose register bytes 0x00, 0x08, 0x10 or 0x18 onward.
// - Overflow set on signed overflow of add, add-with-carry, subtract-with-borrow.
// - Overflow set when multiply product exceeds 255.
// - Overflow set when divide has a zero divisor.
// - Overflow cleared by those instructions when no overflow occurs.
// - Read-only status bit 0 is odd parity of the accumulator.
// - Status word sits at special address 0xD0, byte and bit access.
// - Flash spans 0x0000 to variant top; lock byte last; above is reserved.
// - Code moves read flash; external writes go to XRAM unless redirected.
// - 256 internal RAM bytes; lower 128 by direct and indirect access.
// - Above 0x7F, direct reaches special registers, indirect reaches upper RAM.
// - Bit addresses 0x00-0x7F map to bytes 0x20-0x2F, LSB first.
// - Bit or byte access follows the operation type, not the address.
// - Push writes at pointer plus one, then increments the pointer.
// - Stack pointer resets to 0x07.
// - Stack may use all 256 internal bytes.
// - Only registers 0 and 1 of the active bank serve as pointers.
// - 512 bytes XRAM reached by data pointer or page plus index register.
// - 16-bit external address is page register high, index register low.
module cpu_status_and_data_memory_map
    import cpu_mem_pkg::*;
#(
    parameter logic [15:0] FLASH_TOP = FLASH_TOP_LARGE,
    parameter int unsigned XRAM_BYTES = XRAM_DEPTH
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire logic req_i,
    input wire mem_op_e req_op_i,
    input wire logic [7:0] req_addr_i,
    input wire logic [7:0] req_wdata_i,
    input wire logic alu_req_i,
    input wire alu_op_e alu_op_i,
    input wire logic flash_wr_sel_i,
    output logic [7:0] rd_data_o,
    output logic ack_o,
    output logic busy_o,
    output logic [7:0] program_status_word_o,
    output logic [7:0] acc_o,
    output logic [7:0] b_o,
    output logic [7:0] stack_pointer_o,
    output logic [15:0] data_pointer_16_o,
    output logic flash_rd_o,
    output logic flash_wr_o,
    output logic [15:0] flash_addr_o,
    output logic [7:0] flash_wdata_o,
    output logic addr_err_o
);
    localparam int unsigned XAW = $clog2(XRAM_BYTES);

    generate
        if (FLASH_TOP != FLASH_TOP_LARGE && FLASH_TOP != FLASH_TOP_SMALL) begin : g_bad_top
            $error("FLASH_TOP must be one of the two flash variants");
        end
        if (XRAM_BYTES < 2 || XRAM_BYTES > 65536) begin : g_bad_xram
            $error("XRAM_BYTES out of range");
        end
    endgenerate

    typedef enum logic [1:0] {ST_IDLE, ST_PTR, ST_READ} ctl_state_e;
    typedef enum logic [1:0] {SRC_IRAM, SRC_XRAM, SRC_SFR, SRC_NONE} src_e;

    typedef struct packed {
        ctl_state_e st;
        mem_op_e op;
        src_e src;
        logic [7:0] tgt;
        logic [2:0] bitpos;
        logic [7:0] wdata;
        logic [7:0] sfr_val;
        logic [7:0] sp;
        logic [7:0] acc;
        logic [7:0] b;
        logic [7:0] dpl;
        logic [7:0] dph;
        logic [7:0] page;
        logic carry_flag;
        logic half_carry_flag;
        logic user_flag_zero;
        logic [1:0] reg_bank_select;
        logic overflow_flag;
        logic user_flag_one;
        logic parity;
        logic [7:0] rd_data;
        logic ack;
        logic busy;
        logic flash_rd;
        logic flash_wr;
        logic [15:0] flash_addr;
        logic [7:0] flash_wdata;
        logic addr_err;
    } state_s;

    localparam state_s RESET_STATE = '{
        st: ST_IDLE, op: OP_DIR_RD, src: SRC_IRAM,
        sp: SP_RESET, acc: ACC_RESET, b: B_RESET,
        dpl: DPL_RESET, dph: DPH_RESET, page: PAGE_RESET,
        carry_flag: PSW_RESET[PSW_CY], half_carry_flag: PSW_RESET[PSW_AC],
        user_flag_zero: PSW_RESET[PSW_F0],
        reg_bank_select: PSW_RESET[PSW_RS_HI:PSW_RS_LO],
        overflow_flag: PSW_RESET[PSW_OV], user_flag_one: PSW_RESET[PSW_F1],
        parity: PSW_RESET[PSW_PAR],
        default: '0
    };

    state_s s_reg;
    state_s s_next;

    logic iram_we;
    logic [7:0] iram_addr;
    logic [7:0] iram_wdata;
    logic [7:0] iram_rdata;
    logic xram_we;
    logic [XAW-1:0] xram_addr;
    logic [7:0] xram_wdata;
    logic [7:0] xram_rdata;
    logic [7:0] alu_a;
    logic [7:0] alu_b;
    logic alu_cy;
    logic alu_ac;
    logic alu_ov;

    function automatic logic [7:0] psw_of(input state_s s);
        psw_of = {s.carry_flag, s.half_carry_flag, s.user_flag_zero,
                  s.reg_bank_select, s.overflow_flag, s.user_flag_one, s.parity};
    endfunction

    // Working register byte address in the active bank
    function automatic logic [7:0] bank_reg(input logic [1:0] bank, input logic [2:0] idx);
        bank_reg = {3'b000, bank, idx};
    endfunction

    // Byte that holds a given bit address
    function automatic logic [7:0] bit_byte(input logic [7:0] a);
        if (a < DIRECT_SFR_BASE) begin
            bit_byte = BIT_AREA_BASE + {4'h0, a[6:3]};
        end else begin
            bit_byte = {a[7:3], 3'b000};
        end
    endfunction

    function automatic logic [7:0] sfr_read(input state_s s, input logic [7:0] a);
        unique case (a)
            SFR_SP: sfr_read = s.sp;
            SFR_DPL: sfr_read = s.dpl;
            SFR_DPH: sfr_read = s.dph;
            SFR_PAGE: sfr_read = s.page & PAGE_MASK;
            SFR_PSW: sfr_read = psw_of(s);
            SFR_ACC: sfr_read = s.acc;
            SFR_B: sfr_read = s.b;
            default: sfr_read = 8'h00;
        endcase
    endfunction

    function automatic state_s sfr_write(input state_s s, input logic [7:0] a,
                                         input logic [7:0] d);
        state_s r;
        r = s;
        unique case (a)
            SFR_SP: r.sp = d;
            SFR_DPL: r.dpl = d;
            SFR_DPH: r.dph = d;
            SFR_PAGE: r.page = d & PAGE_MASK;
            SFR_PSW: begin
                r.carry_flag = d[PSW_CY];
                r.half_carry_flag = d[PSW_AC];
                r.user_flag_zero = d[PSW_F0];
                r.reg_bank_select = d[PSW_RS_HI:PSW_RS_LO];
                r.overflow_flag = d[PSW_OV];
                r.user_flag_one = d[PSW_F1];
            end
            SFR_ACC: r.acc = d;
            SFR_B: r.b = d;
            default: r = s;
        endcase
        return r;
    endfunction

    arith_unit u_arith (
        .op_i(alu_op_i),
        .a_i(s_reg.acc),
        .b_i(s_reg.b),
        .cy_i(s_reg.carry_flag),
        .res_a_o(alu_a),
        .res_b_o(alu_b),
        .cy_o(alu_cy),
        .ac_o(alu_ac),
        .ov_o(alu_ov)
    );

    byte_ram #(.DEPTH(IRAM_DEPTH)) u_iram (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .en_i(clk_en_i),
        .we_i(iram_we),
        .addr_i(iram_addr),
        .wdata_i(iram_wdata),
        .rdata_o(iram_rdata)
    );

    byte_ram #(.DEPTH(XRAM_BYTES)) u_xram (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .en_i(clk_en_i),
        .we_i(xram_we),
        .addr_i(xram_addr),
        .wdata_i(xram_wdata),
        .rdata_o(xram_rdata)
    );

    always_comb begin
        logic x_go;
        logic x_wr;
        logic [15:0] x_addr;
        logic [7:0] data;
        logic [7:0] modified;
        x_go = 1'b0;
        x_wr = 1'b0;
        x_addr = 16'h0000;
        data = 8'h00;
        modified = 8'h00;
        s_next = s_reg;
        s_next.ack = 1'b0;
        s_next.flash_rd = 1'b0;
        s_next.flash_wr = 1'b0;
        s_next.addr_err = 1'b0;
        iram_we = 1'b0;
        iram_addr = 8'h00;
        iram_wdata = 8'h00;
        xram_we = 1'b0;
        xram_addr = '0;
        xram_wdata = 8'h00;

        // Arithmetic first so a same-cycle software write wins
        if (alu_req_i) begin
            s_next.acc = alu_a;
            if (alu_op_i == ALU_MUL || alu_op_i == ALU_DIV) begin
                s_next.b = alu_b;
            end
            s_next.carry_flag = alu_cy;
            s_next.half_carry_flag = alu_ac;
            s_next.overflow_flag = alu_ov;
        end

        unique case (s_reg.st)
            ST_IDLE: begin
                if (req_i) begin
                    s_next.op = req_op_i;
                    s_next.wdata = req_wdata_i;
                    s_next.tgt = req_addr_i;
                    s_next.bitpos = req_addr_i[2:0];
                    s_next.src = SRC_IRAM;
                    unique case (req_op_i)
                        OP_DIR_RD: begin
                            if (req_addr_i < DIRECT_SFR_BASE) begin
                                iram_addr = req_addr_i;
                            end else begin
                                s_next.src = SRC_SFR;
                                s_next.sfr_val = sfr_read(s_reg, req_addr_i);
                            end
                            s_next.st = ST_READ;
                        end
                        OP_DIR_WR: begin
                            if (req_addr_i < DIRECT_SFR_BASE) begin
                                iram_we = 1'b1;
                                iram_addr = req_addr_i;
                                iram_wdata = req_wdata_i;
                            end else begin
                                s_next = sfr_write(s_next, req_addr_i, req_wdata_i);
                            end
                            s_next.ack = 1'b1;
                        end
                        OP_REG_RD: begin
                            iram_addr = bank_reg(s_reg.reg_bank_select, req_addr_i[2:0]);
                            s_next.st = ST_READ;
                        end
                        OP_REG_WR: begin
                            iram_we = 1'b1;
                            iram_addr = bank_reg(s_reg.reg_bank_select, req_addr_i[2:0]);
                            iram_wdata = req_wdata_i;
                            s_next.ack = 1'b1;
                        end
                        OP_IND_RD, OP_IND_WR, OP_XRD_PAGE, OP_XWR_PAGE: begin
                            // Pointer is register 0 or 1 only
                            iram_addr = bank_reg(s_reg.reg_bank_select,
                                                 {2'b00, req_addr_i[0]});
                            s_next.st = ST_PTR;
                        end
                        OP_BIT_RD, OP_BIT_WR: begin
                            s_next.tgt = bit_byte(req_addr_i);
                            if (req_addr_i < DIRECT_SFR_BASE) begin
                                iram_addr = bit_byte(req_addr_i);
                            end else begin
                                s_next.src = SRC_SFR;
                                s_next.sfr_val = sfr_read(s_reg, bit_byte(req_addr_i));
                            end
                            s_next.st = ST_READ;
                        end
                        OP_PUSH: begin
                            iram_we = 1'b1;
                            iram_addr = s_reg.sp + 8'h01;
                            iram_wdata = req_wdata_i;
                            s_next.sp = s_reg.sp + 8'h01;
                            s_next.ack = 1'b1;
                        end
                        OP_POP: begin
                            iram_addr = s_reg.sp;
                            s_next.sp = s_reg.sp - 8'h01;
                            s_next.st = ST_READ;
                        end
                        OP_XRD_DATA_POINTER_16, OP_XWR_DATA_POINTER_16: begin
                            x_go = 1'b1;
                            x_wr = (req_op_i == OP_XWR_DATA_POINTER_16);
                            x_addr = {s_reg.dph, s_reg.dpl};
                        end
                        OP_CODE_RD: begin
                            s_next.flash_addr = {s_reg.dph, s_reg.dpl} + {8'h00, s_reg.acc};
                            if (({s_reg.dph, s_reg.dpl} + {8'h00, s_reg.acc}) <= FLASH_TOP) begin
                                s_next.flash_rd = 1'b1;
                            end else begin
                                s_next.addr_err = 1'b1;
                            end
                            s_next.ack = 1'b1;
                        end
                    endcase
                end
            end
            ST_PTR: begin
                unique case (s_reg.op)
                    OP_IND_RD: begin
                        iram_addr = iram_rdata;
                        s_next.src = SRC_IRAM;
                        s_next.st = ST_READ;
                    end
                    OP_IND_WR: begin
                        iram_we = 1'b1;
                        iram_addr = iram_rdata;
                        iram_wdata = s_reg.wdata;
                        s_next.ack = 1'b1;
                        s_next.st = ST_IDLE;
                    end
                    default: begin
                        x_go = 1'b1;
                        x_wr = (s_reg.op == OP_XWR_PAGE);
                        x_addr = {s_reg.page & PAGE_MASK, iram_rdata};
                        s_next.st = ST_IDLE;
                    end
                endcase
            end
            ST_READ: begin
                unique case (s_reg.src)
                    SRC_IRAM: data = iram_rdata;
                    SRC_XRAM: data = xram_rdata;
                    SRC_SFR: data = s_reg.sfr_val;
                    SRC_NONE: data = 8'h00;
                endcase
                modified = data;
                modified[s_reg.bitpos] = s_reg.wdata[0];
                if (s_reg.op == OP_BIT_RD) begin
                    s_next.rd_data = {7'h00, data[s_reg.bitpos]};
                end else if (s_reg.op == OP_BIT_WR) begin
                    if (s_reg.tgt < DIRECT_SFR_BASE) begin
                        iram_we = 1'b1;
                        iram_addr = s_reg.tgt;
                        iram_wdata = modified;
                    end else begin
                        s_next = sfr_write(s_next, s_reg.tgt, modified);
                    end
                end else begin
                    s_next.rd_data = data;
                end
                s_next.ack = 1'b1;
                s_next.st = ST_IDLE;
            end
            default: s_next.st = ST_IDLE;
        endcase

        // External move: XRAM by default, flash for writes when redirected; reads always use XRAM
        if (x_go) begin
            if (x_wr && flash_wr_sel_i) begin
                s_next.flash_addr = x_addr;
                s_next.flash_wdata = s_reg.st == ST_IDLE ? req_wdata_i : s_reg.wdata;
                s_next.flash_wr = (x_addr <= FLASH_TOP);
                s_next.addr_err = (x_addr > FLASH_TOP);
                s_next.ack = 1'b1;
            end else if (x_wr) begin
                xram_we = ({1'b0, x_addr} < 17'(XRAM_BYTES));
                xram_addr = x_addr[XAW-1:0];
                xram_wdata = s_reg.st == ST_IDLE ? req_wdata_i : s_reg.wdata;
                s_next.ack = 1'b1;
            end else begin
                xram_addr = x_addr[XAW-1:0];
                s_next.src = ({1'b0, x_addr} < 17'(XRAM_BYTES)) ? SRC_XRAM : SRC_NONE;
                s_next.st = ST_READ;
            end
        end

        s_next.parity = ^s_next.acc;
        s_next.busy = (s_next.st != ST_IDLE);
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_reg <= RESET_STATE;
        end else if (clk_en_i) begin
            s_reg <= s_next;
        end
    end

    assign rd_data_o = s_reg.rd_data;
    assign ack_o = s_reg.ack;
    assign busy_o = s_reg.busy;
    assign program_status_word_o = psw_of(s_reg);
    assign acc_o = s_reg.acc;
    assign b_o = s_reg.b;
    assign stack_pointer_o = s_reg.sp;
    assign data_pointer_16_o = {s_reg.dph, s_reg.dpl};
    assign flash_rd_o = s_reg.flash_rd;
    assign flash_wr_o = s_reg.flash_wr;
    assign flash_addr_o = s_reg.flash_addr;
    assign flash_wdata_o = s_reg.flash_wdata;
    assign addr_err_o = s_reg.addr_err;
endmodule
`default_nettype wire

//--- src/cpu_mem_pkg.sv
package cpu_mem_pkg;

    // Special register addresses decoded by this block
    localparam logic [7:0] SFR_SP = 8'h81;
    localparam logic [7:0] SFR_DPL = 8'h82;
    localparam logic [7:0] SFR_DPH = 8'h83;
    localparam logic [7:0] SFR_PAGE = 8'hAA;
    localparam logic [7:0] SFR_PSW = 8'hD0;
    localparam logic [7:0] SFR_ACC = 8'hE0;
    localparam logic [7:0] SFR_B = 8'hF0;

    // Reset values
    localparam logic [7:0] SP_RESET = 8'h07;
    localparam logic [7:0] PSW_RESET = 8'h00;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [7:0] B_RESET = 8'h00;
    localparam logic [7:0] DPL_RESET = 8'h00;
    localparam logic [7:0] DPH_RESET = 8'h00;
    localparam logic [7:0] PAGE_RESET = 8'h00;

    // Status word field positions
    localparam int unsigned PSW_CY = 7;
    localparam int unsigned PSW_AC = 6;
    localparam int unsigned PSW_F0 = 5;
    localparam int unsigned PSW_RS_HI = 4;
    localparam int unsigned PSW_RS_LO = 3;
    localparam int unsigned PSW_OV = 2;
    localparam int unsigned PSW_F1 = 1;
    localparam int unsigned PSW_PAR = 0;

    // Only the page select bit of the page register exists
    localparam logic [7:0] PAGE_MASK = 8'h01;

    // Data memory layout
    localparam logic [7:0] DIRECT_SFR_BASE = 8'h80;
    localparam logic [7:0] BIT_AREA_BASE = 8'h20;
    localparam int unsigned IRAM_DEPTH = 256;
    localparam int unsigned XRAM_DEPTH = 512;

    // Program flash ends per variant
    localparam logic [15:0] FLASH_TOP_LARGE = 16'h3BFF;
    localparam logic [15:0] FLASH_TOP_SMALL = 16'h1FFF;

    typedef enum logic [3:0] {
        OP_DIR_RD,
        OP_DIR_WR,
        OP_REG_RD,
        OP_REG_WR,
        OP_IND_RD,
        OP_IND_WR,
        OP_BIT_RD,
        OP_BIT_WR,
        OP_PUSH,
        OP_POP,
        OP_XRD_DATA_POINTER_16,
        OP_XWR_DATA_POINTER_16,
        OP_XRD_PAGE,
        OP_XWR_PAGE,
        OP_CODE_RD
    } mem_op_e;

    typedef enum logic [2:0] {
        ALU_ADD,
        ALU_ADDC,
        ALU_SUBB,
        ALU_MUL,
        ALU_DIV
    } alu_op_e;

endpackage

//--- src/byte_ram.sv
`timescale 1ns/1ps
`default_nettype none
module byte_ram
    import cpu_mem_pkg::*;
#(
    parameter int unsigned DEPTH = 256,
    parameter int unsigned AW = $clog2(DEPTH)
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic en_i,
    input wire logic we_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o
);
    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad
            $error("byte_ram depth must be a power of two");
        end
    endgenerate

    logic [7:0] mem [DEPTH];

    always_ff @(posedge clk_sys_i) begin
        if (en_i && we_i) begin
            mem[addr_i] <= wdata_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= 8'h00;
        end else if (en_i && !we_i) begin
            rdata_o <= mem[addr_i];
        end
    end
endmodule
`default_nettype wire

//--- src/arith_unit.sv
`timescale 1ns/1ps
`default_nettype none
module arith_unit
    import cpu_mem_pkg::*;
(
    input wire alu_op_e op_i,
    input wire logic [7:0] a_i,
    input wire logic [7:0] b_i,
    input wire logic cy_i,
    output logic [7:0] res_a_o,
    output logic [7:0] res_b_o,
    output logic cy_o,
    output logic ac_o,
    output logic ov_o
);
    logic cin;
    logic [8:0] sum9;
    logic [8:0] dif9;
    logic [4:0] sum5;
    logic [4:0] dif5;
    logic [15:0] prod;

    always_comb begin
        cin = (op_i == ALU_ADDC || op_i == ALU_SUBB) ? cy_i : 1'b0;
        sum9 = 9'(a_i) + 9'(b_i) + 9'(cin);
        dif9 = 9'(a_i) - 9'(b_i) - 9'(cin);
        sum5 = 5'(a_i[3:0]) + 5'(b_i[3:0]) + 5'(cin);
        dif5 = 5'(a_i[3:0]) - 5'(b_i[3:0]) - 5'(cin);
        prod = 16'(a_i) * 16'(b_i);
        res_a_o = a_i;
        res_b_o = b_i;
        cy_o = 1'b0;
        ac_o = 1'b0;
        ov_o = 1'b0;
        unique case (op_i)
            ALU_ADD, ALU_ADDC: begin
                res_a_o = sum9[7:0];
                cy_o = sum9[8];
                ac_o = sum5[4];
                ov_o = (a_i[7] == b_i[7]) && (sum9[7] != a_i[7]);
            end
            ALU_SUBB: begin
                res_a_o = dif9[7:0];
                cy_o = dif9[8];
                ac_o = dif5[4];
                ov_o = (a_i[7] != b_i[7]) && (dif9[7] != a_i[7]);
            end
            ALU_MUL: begin
                res_a_o = prod[7:0];
                res_b_o = prod[15:8];
                ov_o = |prod[15:8];
            end
            ALU_DIV: begin
                if (b_i == 8'h00) begin
                    ov_o = 1'b1;
                end else begin
                    res_a_o = a_i / b_i;
                    res_b_o = a_i % b_i;
                end
            end
        endcase
    end
endmodule
`default_nettype wire

//--- verification/flash_stub.sv
`timescale 1ns/1ps
`default_nettype none
module flash_stub (
    input wire logic clk_sys_i,
    input wire logic flash_wr_i,
    input wire logic [15:0] flash_addr_i,
    output logic [15:0] last_addr_o,
    output logic [15:0] wr_count_o = 16'h0000
);
    always @(posedge clk_sys_i) begin
        if (flash_wr_i) begin
            last_addr_o <= flash_addr_i;
            wr_count_o <= wr_count_o + 16'h0001;
        end
    end
endmodule
`default_nettype wire

//--- verification/cpu_mem_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_mem_checker
    import cpu_mem_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire logic req_i,
    input wire mem_op_e req_op_i,
    input wire logic alu_req_i,
    input wire alu_op_e alu_op_i,
    input wire logic ack_o,
    input wire logic busy_o,
    input wire logic [7:0] program_status_word_o,
    input wire logic [7:0] acc_o,
    input wire logic [7:0] b_o,
    input wire logic [7:0] stack_pointer_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    wire logic tk = clk_en_i && req_i && !busy_o;
    wire logic go = clk_en_i && alu_req_i;
    wire logic [8:0] sm = {1'b0, acc_o} + {1'b0, b_o};
    wire logic [4:0] nb = {1'b0, acc_o[3:0]} + {1'b0, b_o[3:0]};
    wire logic [15:0] pr = acc_o * b_o;
    a_sp_reset: assert property ($rose(rst_n_i) |-> stack_pointer_o == SP_RESET)
        else $error("sp reset");
    a_push_incr: assert property (tk && req_op_i == OP_PUSH |=>
        ack_o && stack_pointer_o == $past(stack_pointer_o) + 8'h01) else $error("push");
    a_pop_decr: assert property (tk && req_op_i == OP_POP |=>
        stack_pointer_o == $past(stack_pointer_o) - 8'h01 ##1 ack_o) else $error("pop");
    a_parity_track: assert property (program_status_word_o[0] == ^acc_o)
        else $error("parity");
    a_add_carry: assert property (go && alu_op_i == ALU_ADD |=>
        program_status_word_o[7] == $past(sm[8])) else $error("carry");
    a_add_half: assert property (go && alu_op_i == ALU_ADD |=>
        program_status_word_o[6] == $past(nb[4])) else $error("half carry");
    a_mul_ovf: assert property (go && alu_op_i == ALU_MUL |=>
        program_status_word_o[2] == $past(|pr[15:8])) else $error("mul ov");
    a_div_zero: assert property (go && alu_op_i == ALU_DIV && b_o == 8'h00 |=>
        program_status_word_o[2] && acc_o == $past(acc_o)) else $error("div zero");
endmodule
bind cpu_status_and_data_memory_map cpu_mem_checker chk (.*);
`default_nettype wire

//--- verification/cpu_status_and_data_memory_map_test.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_status_and_data_memory_map_test;
    import cpu_mem_pkg::*;
    logic clk_sys_i = 0, rst_n_i = 0, clk_en_i = 1, req_i = 0, alu_req_i = 0, flash_wr_sel_i = 0;
    mem_op_e req_op_i = OP_DIR_RD;
    alu_op_e alu_op_i = ALU_ADD;
    logic [7:0] req_addr_i = 8'h00, req_wdata_i = 8'h00, rd_data_o, acc_o, b_o, q;
    logic [7:0] program_status_word_o, stack_pointer_o, flash_wdata_o;
    logic [15:0] data_pointer_16_o, flash_addr_o, fa, fc;
    logic ack_o, busy_o, flash_rd_o, flash_wr_o, addr_err_o;
    logic [2:0] f;
    int err_total = 0, samples_checked = 0;
    alu_op_e ops[5] = '{ALU_ADD, ALU_SUBB, ALU_MUL, ALU_DIV, ALU_ADDC};
    logic [31:0] tv[5] = '{32'h7F018045, 32'h0001FFC0, 32'h10100004, 32'h05000504, 32'hFF0100C0};
    cpu_status_and_data_memory_map uut (.*);
    flash_stub fl (.clk_sys_i(clk_sys_i), .flash_wr_i(flash_wr_o), .flash_addr_i(flash_addr_o),
        .last_addr_o(fa), .wr_count_o(fc));
    always #2.5 clk_sys_i = ~clk_sys_i;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic mem(input mem_op_e op, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        req_op_i = op;
        req_addr_i = a;
        req_wdata_i = d;
        req_i = 1;
        @(posedge clk_sys_i);
        #1 req_i = 0;
        while (ack_o !== 1'b1 && n < 8) begin
            @(posedge clk_sys_i);
            #1 n++;
        end
        if (ack_o !== 1'b1) err_total++;
        q = rd_data_o;
        f = {flash_rd_o, flash_wr_o, addr_err_o};
        @(posedge clk_sys_i);
        #1;
    endtask
    task automatic end_of_test;
        $display("checks=%0d mismatches=%0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #20000;
        err_total++;
        end_of_test;
    end
    initial begin
        repeat (3) @(posedge clk_sys_i);
        #1 rst_n_i = 1;
        chk({stack_pointer_o, program_status_word_o}, 16'h0700);
        mem(OP_DIR_WR, SFR_PSW, 8'hFF);
        mem(OP_BIT_WR, SFR_PSW + 8'h05, 8'h00);
        chk(program_status_word_o, 8'hDE);
        for (int i = 0; i < 4; i++) begin
            mem(OP_DIR_WR, SFR_PSW, 8'(i << 3));
            mem(OP_REG_WR, 8'h02, 8'(8'h40 + i));
            mem(OP_DIR_RD, 8'(i * 8 + 2), 8'h00);
            chk(q, 8'(8'h40 + i));
        end
        mem(OP_DIR_WR, 8'h22, 8'h00);
        mem(OP_BIT_WR, 8'h13, 8'h01);
        mem(OP_DIR_RD, 8'h22, 8'h00);
        chk(q, 8'h08);
        mem(OP_PUSH, 8'h00, 8'hA1);
        mem(OP_PUSH, 8'h00, 8'hB2);
        mem(OP_POP, 8'h00, 8'h00);
        chk({q, stack_pointer_o}, 16'hB208);
        $display("stack and bank tests done");
        mem(OP_DIR_WR, SFR_PSW, 8'h00);
        mem(OP_REG_WR, 8'h01, 8'h90);
        mem(OP_IND_WR, 8'h01, 8'h5A);
        mem(OP_IND_RD, 8'h01, 8'h00);
        chk(q, 8'h5A);
        for (int i = 0; i < 5; i++) begin
            mem(OP_DIR_WR, SFR_ACC, tv[i][31:24]);
            mem(OP_DIR_WR, SFR_B, tv[i][23:16]);
            alu_op_i = ops[i];
            alu_req_i = 1;
            @(posedge clk_sys_i);
            #1 alu_req_i = 0;
            chk({acc_o, program_status_word_o}, tv[i][15:0]);
        end
        $display("arithmetic tests done");
        mem(OP_DIR_WR, SFR_PAGE, 8'hFF);
        mem(OP_REG_WR, 8'h00, 8'h34);
        mem(OP_XWR_PAGE, 8'h00, 8'h6C);
        mem(OP_DIR_WR, SFR_DPH, 8'h01);
        mem(OP_DIR_WR, SFR_DPL, 8'h34);
        mem(OP_XRD_DATA_POINTER_16, 8'h00, 8'h00);
        chk(q, 8'h6C);
        mem(OP_XRD_PAGE, 8'h00, 8'h00);
        chk(q, 8'h6C);
        mem(OP_REG_RD, 8'h00, 8'h00);
        chk(q, 8'h34);
        mem(OP_BIT_RD, 8'h13, 8'h00);
        chk(q, 8'h01);
        mem(OP_CODE_RD, 8'h00, 8'h00);
        chk({f, flash_addr_o[12:0]}, 16'h8134);
        chk(data_pointer_16_o, 16'h0134);
        flash_wr_sel_i = 1;
        mem(OP_DIR_WR, SFR_DPH, 8'h3B);
        mem(OP_DIR_WR, SFR_DPL, 8'hFF);
        mem(OP_XWR_DATA_POINTER_16, 8'h00, 8'h11);
        chk({f, 5'h00, flash_wdata_o}, 16'h4011);
        mem(OP_DIR_WR, SFR_DPH, 8'h3C);
        mem(OP_XWR_DATA_POINTER_16, 8'h00, 8'h22);
        chk({f, flash_addr_o[12:0]}, 16'h3CFF);
        chk(fa, 16'h3BFF);
        chk(fc, 16'h0001);
        $display("external memory tests done");
        end_of_test;
    end
endmodule
`default_nettype wire
